// >>> rtl/see_array_access.sv
// serial eeprom command handling: array read, page write with ecc, id page read
`timescale 1ns/10ps
`default_nettype none
module see_array_access #(
  parameter int P_CYCLE_CLKS = see_pkg::SELF_TIMED_CYCLE_TIME_CYCLES
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  input  wire logic i_spi_cs_n,
  input  wire logic i_spi_sclk,
  input  wire logic i_spi_mosi,
  input  wire logic i_area_guard_high,
  input  wire logic i_area_guard_low,
  output var  logic o_spi_miso,
  output var  logic o_spi_miso_oe,
  output var  logic o_write_busy_flag,
  output var  logic o_write_permit_latch
);
  // -----------------------------------------------------------------
  // ecc helpers: hamming single error correction over 32 data bits
  // -----------------------------------------------------------------
  function automatic logic [5:0] ecc_calc(input logic [31:0] d);
    logic [5:0] c;
    logic [5:0] pos;
    c   = '0;
    pos = see_pkg::ECC_FIRST_POS;
    for (int j = 0; j < 32; j++) begin
      if (d[j]) begin
        c = c ^ pos;
      end
      pos = pos + 6'h01;
      if ((pos & (pos - 6'h01)) == 6'h00) begin
        pos = pos + 6'h01;
      end
    end
    return c;
  endfunction

  function automatic logic [31:0] ecc_fix(input logic [31:0] d, input logic [5:0] c);
    logic [5:0]  syn;
    logic [5:0]  pos;
    logic [31:0] r;
    syn = c ^ ecc_calc(d);
    pos = see_pkg::ECC_FIRST_POS;
    r   = d;
    for (int j = 0; j < 32; j++) begin
      if (syn == pos) begin
        r[j] = ~d[j];
      end
      pos = pos + 6'h01;
      if ((pos & (pos - 6'h01)) == 6'h00) begin
        pos = pos + 6'h01;
      end
    end
    return r;
  endfunction

  // -----------------------------------------------------------------
  // pin synchronisers and edge detection
  // -----------------------------------------------------------------
  logic cs_s1_r, cs_s2_r, cs_s3_r;
  logic ck_s1_r, ck_s2_r, ck_s3_r;
  logic di_s1_r, di_s2_r;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cs_s1_r <= 1'b1;
      cs_s2_r <= 1'b1;
      cs_s3_r <= 1'b1;
      ck_s1_r <= 1'b0;
      ck_s2_r <= 1'b0;
      ck_s3_r <= 1'b0;
      di_s1_r <= 1'b0;
      di_s2_r <= 1'b0;
    end else begin
      cs_s1_r <= i_spi_cs_n;
      cs_s2_r <= cs_s1_r;
      cs_s3_r <= cs_s2_r;
      ck_s1_r <= i_spi_sclk;
      ck_s2_r <= ck_s1_r;
      ck_s3_r <= ck_s2_r;
      di_s1_r <= i_spi_mosi;
      di_s2_r <= di_s1_r;
    end
  end

  logic sel;
  logic cs_rise;
  logic cs_fall;
  logic sck_rise;
  logic sck_fall;
  assign sel      = ~cs_s2_r;
  assign cs_rise  = cs_s2_r & ~cs_s3_r;
  assign cs_fall  = ~cs_s2_r & cs_s3_r;
  assign sck_rise = sel & ck_s2_r & ~ck_s3_r;
  assign sck_fall = sel & ~ck_s2_r & ck_s3_r;

  // -----------------------------------------------------------------
  // storage: 32-bit groups with check bits, page buffer
  // -----------------------------------------------------------------
  logic [31:0] mem_data [see_pkg::WORDS];
  logic [5:0]  mem_chk  [see_pkg::WORDS];
  logic [31:0] pbuf     [32];
  logic [3:0]  pmask_r  [32];

  // -----------------------------------------------------------------
  // frame decoding
  // -----------------------------------------------------------------
  logic [4:0]  cnt_r;
  logic [15:0] sh_r;
  logic [7:0]  op_r;
  logic [15:0] addr_r;
  logic        wr_ok_r;
  logic        wr_data_r;
  logic        rd_arr_r;
  logic        rd_id_r;
  logic        busy_r;
  logic        wel_r;
  logic [15:0] sh_nxt;
  logic        guarded;
  assign sh_nxt = {sh_r[14:0], di_s2_r};
  // upper quarter, upper half or whole array is write-guarded
  always_comb begin
    guarded = 1'b0;
    if (i_area_guard_high && i_area_guard_low) begin
      guarded = 1'b1;
    end else if (i_area_guard_high) begin
      guarded = sh_nxt[15];
    end else if (i_area_guard_low) begin
      guarded = &sh_nxt[15:14];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !sel) begin
      cnt_r <= '0;
      sh_r  <= '0;
    end else if (sck_rise) begin
      sh_r  <= sh_nxt;
      // after the address, the count cycles over data bit positions
      cnt_r <= (cnt_r == see_pkg::CNT_DATA_LAST) ? see_pkg::CNT_DATA_FIRST : cnt_r + 5'h01;
    end
  end
  logic rd_go;
  assign rd_go = sck_rise && cnt_r == see_pkg::CNT_ADDR_LAST && !busy_r;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !sel) begin
      op_r      <= '0;
      wr_ok_r   <= 1'b0;
      wr_data_r <= 1'b0;
      rd_arr_r  <= 1'b0;
      rd_id_r   <= 1'b0;
    end else if (sck_rise) begin
      if (cnt_r == see_pkg::CNT_OP_LAST) begin
        op_r <= sh_nxt[7:0];
      end
      if (cnt_r == see_pkg::CNT_ADDR_LAST && op_r == see_pkg::OP_ARRAY_WRITE) begin
        wr_ok_r <= wel_r && !busy_r && !guarded;
      end
      if (rd_go && op_r == see_pkg::OP_ARRAY_READ) begin
        rd_arr_r <= 1'b1;
      end
      if (rd_go && op_r == see_pkg::OP_ID_READ && !sh_nxt[10]) begin
        rd_id_r <= 1'b1;
      end
      if (cnt_r == see_pkg::CNT_DATA_LAST && wr_ok_r) begin
        wr_data_r <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // address counter and page buffer capture
  // -----------------------------------------------------------------
  logic load_byte;
  assign load_byte = sck_fall && cnt_r == see_pkg::CNT_DATA_FIRST && (rd_arr_r || rd_id_r);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      addr_r <= '0;
    end else if (sck_rise && cnt_r == see_pkg::CNT_ADDR_LAST) begin
      addr_r <= sh_nxt;
    end else if (load_byte && rd_arr_r) begin
      addr_r <= addr_r + 16'h0001;
    end else if (load_byte) begin
      addr_r[6:0] <= addr_r[6:0] + 7'h01;
    end else if (sck_rise && cnt_r == see_pkg::CNT_DATA_LAST && wr_ok_r) begin
      addr_r[6:0] <= addr_r[6:0] + 7'h01;
    end
  end

  // -----------------------------------------------------------------
  // write engine: merge, erase, program, then hold out the cycle time
  // -----------------------------------------------------------------
  see_pkg::see_wr_state_e st_r;
  logic [4:0]  grp_r;
  logic [8:0]  page_r;
  logic [31:0] tmr_r;
  logic        commit;
  logic [13:0] eng_idx;
  logic [13:0] rd_idx;
  logic [31:0] rd_word;

  // only a rise right after bit b0 of a data byte commits
  assign commit  = cs_rise && wr_data_r && cnt_r == see_pkg::CNT_DATA_FIRST;
  assign eng_idx = {page_r, grp_r};
  assign rd_idx  = busy_r ? eng_idx : addr_r[15:2];
  assign rd_word = ecc_fix(mem_data[rd_idx], mem_chk[rd_idx]);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_r   <= see_pkg::SEE_IDLE;
      grp_r  <= '0;
      page_r <= '0;
      tmr_r  <= '0;
      busy_r <= 1'b0;
    end else begin
      case (st_r)
        see_pkg::SEE_IDLE: begin
          if (commit) begin
            st_r   <= see_pkg::SEE_MERGE;
            page_r <= addr_r[15:7];
            grp_r  <= '0;
            tmr_r  <= '0;
            busy_r <= 1'b1;
          end
        end
        see_pkg::SEE_MERGE, see_pkg::SEE_ERASE, see_pkg::SEE_PROG: begin
          tmr_r <= tmr_r + 32'h1;
          grp_r <= grp_r + 5'h01;
          if (grp_r == see_pkg::LAST_GROUP) begin
            if (st_r == see_pkg::SEE_MERGE) begin
              st_r <= see_pkg::SEE_ERASE;
            end else if (st_r == see_pkg::SEE_ERASE) begin
              st_r <= see_pkg::SEE_PROG;
            end else begin
              st_r <= see_pkg::SEE_WAIT;
            end
          end
        end
        see_pkg::SEE_WAIT: begin
          tmr_r <= tmr_r + 32'h1;
          if (tmr_r >= 32'(P_CYCLE_CLKS - 1)) begin
            st_r   <= see_pkg::SEE_IDLE;
            busy_r <= 1'b0;
          end
        end
        default: begin
          st_r <= see_pkg::SEE_IDLE;
        end
      endcase
    end
  end

  // single writer of the page buffer: capture bytes, then merge untouched ones
  always_ff @(posedge i_clk_sys) begin
    if (sck_rise && cnt_r == see_pkg::CNT_DATA_LAST && wr_ok_r) begin
      pbuf[addr_r[6:2]][addr_r[1:0]*8 +: 8] <= sh_nxt[7:0];
    end else if (st_r == see_pkg::SEE_MERGE && pmask_r[grp_r] != 4'h0) begin
      for (int b = 0; b < 4; b++) begin
        if (!pmask_r[grp_r][b]) begin
          pbuf[grp_r][b*8 +: 8] <= rd_word[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (pmask_r[grp_r] != 4'h0) begin
      if (st_r == see_pkg::SEE_ERASE) begin
        mem_data[eng_idx] <= '0;
        mem_chk[eng_idx]  <= '0;
      end else if (st_r == see_pkg::SEE_PROG) begin
        mem_data[eng_idx] <= pbuf[grp_r];
        mem_chk[eng_idx]  <= ecc_calc(pbuf[grp_r]);
      end
    end
  end

  generate
    for (genvar g = 0; g < 32; g++) begin : g_mask
      always_ff @(posedge i_clk_sys) begin
        if (i_rst || (cs_fall && !busy_r) || (cs_rise && !commit && !busy_r)) begin
          pmask_r[g] <= '0;
        end else if (sck_rise && cnt_r == see_pkg::CNT_DATA_LAST && wr_ok_r && addr_r[6:2] == g) begin
          pmask_r[g][addr_r[1:0]] <= 1'b1;
        end
      end
    end
  endgenerate

  // -----------------------------------------------------------------
  // write permit latch
  // -----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wel_r <= 1'b0;
    end else if (st_r == see_pkg::SEE_WAIT && tmr_r >= 32'(P_CYCLE_CLKS - 1)) begin
      wel_r <= 1'b0;
    end else if (cs_rise && !busy_r && op_r == see_pkg::OP_WRITE_PERMIT
                 && cnt_r == 5'h08) begin
      wel_r <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // serial output: loaded on falling edge, msb first
  // -----------------------------------------------------------------
  logic [7:0] so_r;
  logic [7:0] byte_now;
  assign byte_now = rd_id_r ? see_pkg::ID_FILL : rd_word[addr_r[1:0]*8 +: 8];

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !sel) begin
      so_r          <= '0;
      o_spi_miso    <= 1'b0;
      o_spi_miso_oe <= 1'b0;
    end else begin
      o_spi_miso_oe <= rd_arr_r || rd_id_r;
      if (load_byte) begin
        so_r       <= {byte_now[6:0], 1'b0};
        o_spi_miso <= byte_now[7];
      end else if (sck_fall && (rd_arr_r || rd_id_r)) begin
        so_r       <= {so_r[6:0], 1'b0};
        o_spi_miso <= so_r[7];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_write_busy_flag    <= 1'b0;
      o_write_permit_latch <= 1'b0;
    end else begin
      o_write_busy_flag    <= busy_r;
      o_write_permit_latch <= wel_r;
    end
  end
endmodule // see_array_access
`default_nettype wire

// >>> rtl/see_pkg.sv
// constants and types for the serial eeprom array access block
package see_pkg;
  // -----------------------------------------------------------------
  // command codes
  // -----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_PERMIT = 8'h06;
  localparam logic [7:0] OP_ARRAY_WRITE  = 8'h02;
  localparam logic [7:0] OP_ARRAY_READ   = 8'h03;
  localparam logic [7:0] OP_ID_READ      = 8'h83;
  // -----------------------------------------------------------------
  // frame bit positions (counted on serial clock rising edges)
  // -----------------------------------------------------------------
  localparam logic [4:0] CNT_OP_LAST    = 5'h07;
  localparam logic [4:0] CNT_ADDR_LAST  = 5'h17;
  localparam logic [4:0] CNT_DATA_FIRST = 5'h18;
  localparam logic [4:0] CNT_DATA_LAST  = 5'h1f;
  // -----------------------------------------------------------------
  // array geometry and fill values
  // -----------------------------------------------------------------
  localparam int         ADDR_W        = 16;
  localparam int         PAGE_BITS     = 7;
  localparam int         WORDS         = 16384;
  localparam logic [4:0] LAST_GROUP    = 5'h1f;
  localparam logic [7:0] ID_FILL       = 8'hff;
  localparam logic [5:0] ECC_FIRST_POS = 6'h03;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS                 = 100;
  localparam int SELF_TIMED_CYCLE_TIME_NS      = 5000000;
  localparam int SELF_TIMED_CYCLE_TIME_CYCLES  =
    (SELF_TIMED_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // -----------------------------------------------------------------
  // write engine states
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEE_IDLE,
    SEE_MERGE,
    SEE_ERASE,
    SEE_PROG,
    SEE_WAIT
  } see_wr_state_e;
endpackage

// >>> verif/see_spi_host.sv
// spi host model driving select, serial clock and data into the eeprom block
`timescale 1ns/10ps
`default_nettype none
module see_spi_host (
  input  wire logic i_clk_sys,
  input  wire logic i_miso,
  output var  logic o_cs_n,
  output var  logic o_sclk,
  output var  logic o_mosi
);
  int half = 5;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_mosi = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic sel();
    wt(1);
    o_cs_n = 1'b0;
    wt(half);
  endtask
  // mode 0: data set while sclk low, taken on the rise
  task automatic xb(input logic [7:0] t, input int n, output logic [7:0] r);
    r = 8'h00;
    for (int i = 0; i < n; i++) begin
      o_mosi = t[7 - i];
      repeat (half) @(posedge i_clk_sys);
      // sample once the edge has settled, never in its own time step
      #1;
      r = {r[6:0], i_miso};
      o_sclk = 1'b1;
      wt(half);
      o_sclk = 1'b0;
    end
  endtask
  task automatic desel();
    wt(half);
    o_cs_n = 1'b1;
    // a released line must not keep showing its last bit
    o_mosi = ~o_mosi;
    wt(2 * half);
  endtask
endmodule // see_spi_host
`default_nettype wire

// >>> verif/see_array_access_monitor.sv
// port checker for the serial eeprom array access block
`timescale 1ns/10ps
`default_nettype none
module see_array_access_monitor #(
  parameter int P_CYCLE_CLKS = see_pkg::SELF_TIMED_CYCLE_TIME_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_spi_cs_n,
  input wire logic i_spi_sclk,
  input wire logic i_spi_mosi,
  input wire logic i_area_guard_high,
  input wire logic i_area_guard_low,
  input wire logic o_spi_miso,
  input wire logic o_spi_miso_oe,
  input wire logic o_write_busy_flag,
  input wire logic o_write_permit_latch
);
  int busy_cnt_r;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !o_write_busy_flag) busy_cnt_r <= 0;
    else busy_cnt_r <= busy_cnt_r + 1;
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  busy_len_a: assert property ($fell(o_write_busy_flag) |-> busy_cnt_r == P_CYCLE_CLKS)
    else $error("busy length wrong");
  latch_clear_a: assert property ($fell(o_write_busy_flag) |-> ##[0:2] !o_write_permit_latch)
    else $error("permit latch not cleared");
  busy_permit_a: assert property ($rose(o_write_busy_flag) |-> o_write_permit_latch)
    else $error("write started without permit");
  busy_desel_a: assert property ($rose(o_write_busy_flag) |-> i_spi_cs_n && $past(i_spi_cs_n, 2))
    else $error("write started while selected");
  guard_all_a: assert property ($rose(o_write_busy_flag) |-> !(i_area_guard_high && i_area_guard_low))
    else $error("write started in guarded array");
  read_busy_a: assert property ($rose(o_spi_miso_oe) |-> !o_write_busy_flag && !i_spi_cs_n)
    else $error("read accepted while busy");
  oe_drop_a: assert property ($rose(i_spi_cs_n) |-> ##[1:8] !o_spi_miso_oe)
    else $error("output enable stays after deselect");
  miso_hold_a: assert property ($rose(i_spi_sclk) && o_spi_miso_oe |-> ##1 $stable(o_spi_miso) [*3])
    else $error("miso moved around sclk rise");
  busy_cover_c: cover property ($rose(o_write_busy_flag));
  oe_cover_c: cover property ($rose(o_spi_miso_oe));
  latch_cover_c: cover property ($rose(o_write_permit_latch));
endmodule // see_array_access_monitor
bind see_array_access see_array_access_monitor #(.P_CYCLE_CLKS(P_CYCLE_CLKS)) mon (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_spi_cs_n(i_spi_cs_n), .i_spi_sclk(i_spi_sclk),
  .i_spi_mosi(i_spi_mosi), .i_area_guard_high(i_area_guard_high), .i_area_guard_low(i_area_guard_low),
  .o_spi_miso(o_spi_miso), .o_spi_miso_oe(o_spi_miso_oe), .o_write_busy_flag(o_write_busy_flag),
  .o_write_permit_latch(o_write_permit_latch));
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking testbench for the serial eeprom array access block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // must exceed the time to shift an opcode and address, so a read can land inside it
  localparam int P_CYC = 400;
  logic i_clk_sys, i_rst, cs_n, sclk, mosi, g_hi, g_lo, miso, oe, busy, permit, oe_seen;
  logic [7:0] r;
  int err_count = 0;
  int cmp_count = 0;
  see_array_access #(.P_CYCLE_CLKS(P_CYC)) uut (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_spi_cs_n(cs_n),
    .i_spi_sclk(sclk), .i_spi_mosi(mosi), .i_area_guard_high(g_hi), .i_area_guard_low(g_lo),
    .o_spi_miso(miso), .o_spi_miso_oe(oe), .o_write_busy_flag(busy), .o_write_permit_latch(permit));
  see_spi_host host (.i_clk_sys(i_clk_sys), .i_miso(miso), .o_cs_n(cs_n), .o_sclk(sclk), .o_mosi(mosi));
  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) if (oe === 1'b1) oe_seen = 1'b1;
  // -----------------------------------------------------------------
  // tasks
  // -----------------------------------------------------------------
  task automatic end_sim();
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic hdr(input logic [7:0] op, input logic [15:0] a);
    host.sel();
    host.xb(op, 8, r);
    host.xb(a[15:8], 8, r);
    host.xb(a[7:0], 8, r);
  endtask
  task automatic permit_cmd();
    host.sel();
    host.xb(see_pkg::OP_WRITE_PERMIT, 8, r);
    host.desel();
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d[$], input int tail, input logic perm);
    if (perm) permit_cmd();
    hdr(see_pkg::OP_ARRAY_WRITE, a);
    foreach (d[i]) host.xb(d[i], 8, r);
    if (tail > 0) host.xb(8'h00, tail, r);
    host.desel();
  endtask
  task automatic wait_idle();
    for (int i = 0; i < P_CYC + 200 && busy !== 1'b0; i++) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic rd(input logic [7:0] op, input logic [15:0] a, input logic [7:0] e[$], input logic oe_exp);
    hdr(op, a);
    oe_seen = 1'b0;
    foreach (e[i]) begin
      host.xb(8'h00, 8, r);
      if (oe_exp) chk(r, e[i]);
    end
    host.desel();
    chk({7'h00, oe_seen}, {7'h00, oe_exp});
  endtask
  // -----------------------------------------------------------------
  // tests
  // -----------------------------------------------------------------
  initial begin
    #3_000_000;
    err_count++;
    end_sim();
  end
  initial begin
    i_rst = 1'b1;
    g_hi = 1'b0;
    g_lo = 1'b0;
    oe_seen = 1'b0;
    repeat (12) @(posedge i_clk_sys);
    #1 i_rst = 1'b0;
    host.wt(5);
    chk({6'h00, busy, permit}, 8'h00);
    wr(16'h0040, '{8'h11}, 0, 1'b0);
    chk({7'h00, busy}, 8'h00);
    wr(16'hfffe, '{8'ha1, 8'hc6, 8'ha3, 8'ha4}, 0, 1'b1);
    chk({7'h00, busy}, 8'h01);
    rd(see_pkg::OP_ARRAY_READ, 16'hfffe, '{8'h00}, 1'b0);
    wait_idle();
    chk({6'h00, busy, permit}, 8'h00);
    wr(16'h0000, '{8'h5c}, 0, 1'b1);
    wait_idle();
    rd(see_pkg::OP_ARRAY_READ, 16'hfffe, '{8'ha1, 8'hc6, 8'h5c}, 1'b1);
    rd(see_pkg::OP_ARRAY_READ, 16'hff80, '{8'ha3, 8'ha4}, 1'b1);
    hdr(see_pkg::OP_ARRAY_READ, 16'hffff);
    host.xb(8'h00, 3, r);
    host.desel();
    chk(r, 8'h06);
    wr(16'h0001, '{8'h77}, 4, 1'b1);
    chk({7'h00, busy}, 8'h00);
    for (int g = 1; g < 4; g++) begin
      {g_hi, g_lo} = g[1:0];
      // lowest address of the guarded region: c000, 8000, then 0000
      wr(16'(32'h0001_0000 - (32'h0000_4000 << (g - 1))), '{8'h99}, 0, 1'b1);
      chk({7'h00, busy}, 8'h00);
    end
    {g_hi, g_lo} = 2'b00;
    rd(see_pkg::OP_ARRAY_READ, 16'h0000, '{8'h5c}, 1'b1);
    rd(see_pkg::OP_ID_READ, 16'h807e, '{8'hff, 8'hff}, 1'b1);
    rd(see_pkg::OP_ID_READ, 16'h0400, '{8'hff}, 1'b0);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
